// file: rtl/rts_pkg.sv
// Shared constants and types of the reset and start-up sequencer.
package rts_pkg;
    // Register map, byte addresses on the APB side.
    localparam logic [7:0] RTS_OFS_CTRL = 8'h00;
    localparam logic [7:0] RTS_OFS_PSR = 8'h04;
    localparam logic [7:0] RTS_OFS_STAT = 8'h08;
    // Control register fields.
    localparam int RTS_CTRL_DROOP_EN = 0;
    localparam int RTS_CTRL_DELAY_EN_N = 1;
    localparam int RTS_CTRL_MODE_LSB = 2;
    localparam logic [3:0] RTS_CTRL_RESET = 4'h0;
    // Power status register fields.
    localparam int RTS_PSR_DROOP_N = 0;
    localparam int RTS_PSR_POR_N = 1;
    localparam logic [1:0] RTS_PSR_RESET = 2'h0;
    // Processor status and interrupt control fields.
    localparam int RTS_ST_EXPIRY = 4;
    localparam int RTS_ST_SLEEP = 3;
    localparam int RTS_IC_GIE = 7;
    localparam logic [2:0] RTS_ST_HI_CLR = 3'h0;
    localparam logic [6:0] RTS_IC_HI_CLR = 7'h00;
    localparam logic [12:0] RTS_PC_RESET = 13'h0000;
    localparam logic [12:0] RTS_PC_IRQ_VEC = 13'h0004;
    localparam logic [12:0] RTS_PC_STEP = 13'h0001;
    // Timing figures.
    localparam int RTS_CLK_MHZ = 250;
    localparam int RTS_DROOP_FILTER_US = 100;
    localparam int RTS_POWERUP_DELAY_MS = 72;
    localparam int RTS_SETTLE_CYCLES = 1024;
    localparam int RTS_CNT_W = 24;

    typedef enum logic [1:0] {
        RTS_MODE_LOWPOWER = 2'b00,
        RTS_MODE_STANDARD = 2'b01,
        RTS_MODE_FAST = 2'b10,
        RTS_MODE_RC = 2'b11
    } rts_osc_mode_t;

    typedef enum logic [2:0] {
        RTS_ST_RUN = 3'b000,
        RTS_ST_DROOP = 3'b001,
        RTS_ST_DELAY = 3'b010,
        RTS_ST_SETTLE = 3'b011,
        RTS_ST_APPLY = 3'b100
    } rts_state_t;

    typedef enum logic [2:0] {
        RTS_C_POR = 3'b000,
        RTS_C_DROOP = 3'b001,
        RTS_C_PIN_RUN = 3'b010,
        RTS_C_PIN_SLEEP = 3'b011,
        RTS_C_WDT = 3'b100,
        RTS_C_WAKE_WDT = 3'b101,
        RTS_C_WAKE_IRQ = 3'b110
    } rts_cause_t;
endpackage

// file: rtl/rts_sequencer.sv
// Reset and start-up sequencer with cause decode and register init values.
`timescale 1ns/1ps
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int INTOSC_KHZ = 1000,
    parameter int DROOP_FILTER_CYC = RTS_DROOP_FILTER_US * RTS_CLK_MHZ,
    parameter int POWERUP_TICKS = RTS_POWERUP_DELAY_MS * INTOSC_KHZ
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_por_pulse,
    input wire logic i_droop,
    input wire logic i_ext_reset_n,
    input wire logic i_wdt_expire,
    input wire logic i_irq_wake,
    input wire logic i_in_sleep,
    input wire logic i_osc_tick,
    input wire logic i_intosc_tick,
    input wire logic [12:0] i_pc,
    input wire logic [7:0] i_status,
    input wire logic [7:0] i_irq_control_reg,
    input wire logic [7:0] i_wake_flags,
    output logic o_core_reset_n,
    output logic o_pc_load,
    output logic [12:0] o_pc_value,
    output logic o_status_load,
    output logic [7:0] o_status_value,
    output logic o_irq_control_reg_load,
    output logic [7:0] o_irq_control_reg_value,
    output logic o_pc_high_clear
);
    localparam logic [RTS_CNT_W-1:0] DELAY_LAST =
        RTS_CNT_W'(POWERUP_TICKS - 1);
    localparam logic [RTS_CNT_W-1:0] SETTLE_LAST =
        RTS_CNT_W'(RTS_SETTLE_CYCLES - 1);
    localparam logic [RTS_CNT_W-1:0] FILT_LAST =
        RTS_CNT_W'(DROOP_FILTER_CYC - 1);
    localparam logic [RTS_CNT_W-1:0] CNT_ONE = RTS_CNT_W'(1);

    // Processor status value for each cause; u bits come from the core.
    function automatic logic [7:0] status_for(input rts_cause_t c,
                                              input logic [7:0] s);
        logic [7:0] v;
        v = s;
        unique case (c)
            RTS_C_POR, RTS_C_DROOP:
            begin
                v[7:5] = RTS_ST_HI_CLR;
                v[RTS_ST_EXPIRY] = 1'b1;
                v[RTS_ST_SLEEP] = 1'b1;
            end
            RTS_C_PIN_RUN:
            begin
                v[7:5] = RTS_ST_HI_CLR;
            end
            RTS_C_PIN_SLEEP:
            begin
                v[7:5] = RTS_ST_HI_CLR;
                v[RTS_ST_EXPIRY] = 1'b1;
                v[RTS_ST_SLEEP] = 1'b0;
            end
            RTS_C_WDT:
            begin
                v[7:5] = RTS_ST_HI_CLR;
                v[RTS_ST_EXPIRY] = 1'b0;
                v[RTS_ST_SLEEP] = 1'b1;
            end
            RTS_C_WAKE_WDT:
            begin
                v[RTS_ST_EXPIRY] = 1'b0;
                v[RTS_ST_SLEEP] = 1'b0;
            end
            RTS_C_WAKE_IRQ:
            begin
                v[RTS_ST_EXPIRY] = 1'b1;
                v[RTS_ST_SLEEP] = 1'b0;
            end
            default:
            begin
                v = s;
            end
        endcase
        return v;
    endfunction

    // Two-flop synchronisers for power-on, droop and pin.
    logic [2:0] async_in;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    assign async_in = {i_ext_reset_n, i_droop, i_por_pulse};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge i_clk_sys or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate
    wire por_s = sync2_r[0];
    wire droop_s = sync2_r[1];
    wire pin_s = sync2_r[2];

    logic [3:0] ctrl_r;
    logic [1:0] psr_r;
    rts_state_t state_r;
    rts_state_t state_nxt;
    rts_cause_t cause_r;
    rts_cause_t cause_nxt;
    logic [RTS_CNT_W-1:0] cnt_r;
    logic [RTS_CNT_W-1:0] filt_r;
    logic pin_d_r;

    wire droop_en = ctrl_r[RTS_CTRL_DROOP_EN];
    wire rts_osc_mode_t osc_mode =
        rts_osc_mode_t'(ctrl_r[RTS_CTRL_MODE_LSB +: 2]);
    wire crystal = (osc_mode != RTS_MODE_RC);
    wire delay_on = !ctrl_r[RTS_CTRL_DELAY_EN_N] || droop_en;
    wire droop_on = droop_s && droop_en;
    wire droop_trip = droop_on && (filt_r == FILT_LAST);
    wire pin_fall = pin_d_r && !pin_s;
    wire delay_done = i_intosc_tick && (cnt_r == DELAY_LAST);
    wire settle_done = i_osc_tick && (cnt_r == SETTLE_LAST);
    wire rts_state_t after_delay = crystal ? RTS_ST_SETTLE : RTS_ST_APPLY;

    // Sequence control; power-on beats droop, droop beats pin and watchdog.
    always_comb
    begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        if (por_s)
        begin
            cause_nxt = RTS_C_POR;
            state_nxt = delay_on ? RTS_ST_DELAY : after_delay;
        end
        else if (droop_trip && state_r != RTS_ST_DROOP)
        begin
            cause_nxt = RTS_C_DROOP;
            state_nxt = RTS_ST_DROOP;
        end
        else
        begin
            unique case (state_r)
                RTS_ST_RUN:
                begin
                    if (pin_fall)
                    begin
                        cause_nxt = i_in_sleep ? RTS_C_PIN_SLEEP
                                               : RTS_C_PIN_RUN;
                        state_nxt = RTS_ST_APPLY;
                    end
                    else if (i_wdt_expire && i_in_sleep)
                    begin
                        cause_nxt = RTS_C_WAKE_WDT;
                        state_nxt = after_delay;
                    end
                    else if (i_wdt_expire)
                    begin
                        cause_nxt = RTS_C_WDT;
                        state_nxt = RTS_ST_APPLY;
                    end
                    else if (i_irq_wake && i_in_sleep)
                    begin
                        cause_nxt = RTS_C_WAKE_IRQ;
                        state_nxt = after_delay;
                    end
                end
                RTS_ST_DROOP:
                begin
                    if (!droop_s)
                    begin
                        state_nxt = RTS_ST_DELAY;
                    end
                end
                RTS_ST_DELAY:
                begin
                    if (cause_r == RTS_C_DROOP && droop_on)
                    begin
                        state_nxt = RTS_ST_DROOP;
                    end
                    else if (delay_done)
                    begin
                        state_nxt = after_delay;
                    end
                end
                RTS_ST_SETTLE:
                begin
                    if (settle_done)
                    begin
                        state_nxt = RTS_ST_APPLY;
                    end
                end
                RTS_ST_APPLY:
                begin
                    state_nxt = RTS_ST_RUN;
                end
                default:
                begin
                    state_nxt = RTS_ST_RUN;
                end
            endcase
        end
    end

    // Values loaded into the core when the sequence ends.
    wire is_wake = (cause_r == RTS_C_WAKE_WDT) || (cause_r == RTS_C_WAKE_IRQ);
    wire irq_vec = (cause_r == RTS_C_WAKE_IRQ) && i_irq_control_reg[RTS_IC_GIE];
    wire [12:0] pc_nxt = !is_wake ? RTS_PC_RESET :
        (irq_vec ? RTS_PC_IRQ_VEC : i_pc + RTS_PC_STEP);
    wire [7:0] status_nxt = status_for(cause_r, i_status);
    wire [7:0] irq_control_reg_nxt = is_wake ? (i_irq_control_reg | i_wake_flags)
        : {RTS_IC_HI_CLR, i_irq_control_reg[0]};
    wire apply = (state_r == RTS_ST_APPLY);

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= RTS_ST_RUN;
            cause_r <= RTS_C_POR;
            pin_d_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            pin_d_r <= pin_s;
        end
    end

    // Delay counter restarts on every state change.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_r <= '0;
        end
        else if (state_nxt != state_r || por_s)
        begin
            cnt_r <= '0;
        end
        else if ((state_r == RTS_ST_DELAY && i_intosc_tick) ||
                 (state_r == RTS_ST_SETTLE && i_osc_tick))
        begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // Droop filter counts system cycles of a continuous droop.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            filt_r <= '0;
        end
        else if (!droop_on)
        begin
            filt_r <= '0;
        end
        else if (filt_r != FILT_LAST)
        begin
            filt_r <= filt_r + CNT_ONE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pc_load <= 1'b0;
            o_status_load <= 1'b0;
            o_irq_control_reg_load <= 1'b0;
            o_pc_high_clear <= 1'b0;
            o_pc_value <= RTS_PC_RESET;
            o_status_value <= '0;
            o_irq_control_reg_value <= '0;
        end
        else
        begin
            o_pc_load <= apply;
            o_status_load <= apply;
            o_irq_control_reg_load <= apply;
            o_pc_high_clear <= apply && !is_wake;
            if (apply)
            begin
                o_pc_value <= pc_nxt;
                o_status_value <= status_nxt;
                o_irq_control_reg_value <= irq_control_reg_nxt;
            end
        end
    end

    // Core leaves reset only from run with the pin high.
    assign o_core_reset_n = (state_r == RTS_ST_RUN) && pin_s;

    // APB slave with no wait states.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = (paddr == RTS_OFS_CTRL);
    wire hit_psr = (paddr == RTS_OFS_PSR);
    wire hit_stat = (paddr == RTS_OFS_STAT);
    wire mapped = hit_ctrl || hit_psr || (hit_stat && !pwrite);
    wire wr = access && pwrite && mapped;
    wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, ctrl_r} :
        hit_psr ? {30'h00000000, psr_r} :
        hit_stat ? {26'h0000000, cause_r, state_r} : 32'h00000000;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prdata <= '0;
            ctrl_r <= RTS_CTRL_RESET;
        end
        else
        begin
            if (setup && !pwrite)
            begin
                prdata <= rd_mux;
            end
            if (wr && hit_ctrl)
            begin
                ctrl_r <= pwdata[3:0];
            end
        end
    end

    // Status bits: a hardware clear beats a software write.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            psr_r <= RTS_PSR_RESET;
        end
        else
        begin
            if (por_s)
            begin
                psr_r[RTS_PSR_POR_N] <= 1'b0;
            end
            else if (wr && hit_psr)
            begin
                psr_r[RTS_PSR_POR_N] <= pwdata[RTS_PSR_POR_N];
            end
            // The droop bit is never read by the sequence itself.
            if (droop_trip && !por_s)
            begin
                psr_r[RTS_PSR_DROOP_N] <= 1'b0;
            end
            else if (wr && hit_psr)
            begin
                psr_r[RTS_PSR_DROOP_N] <= pwdata[RTS_PSR_DROOP_N];
            end
        end
    end
endmodule // rts_sequencer

// file: test/rts_seq_props.sv
// Checker of the sequencer's reset output and register load pulses.
`timescale 1ns/1ps
module rts_seq_props
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic pready,
    input wire logic i_por_pulse,
    input wire logic i_droop,
    input wire logic i_wdt_expire,
    input wire logic i_in_sleep,
    input wire logic o_core_reset_n,
    input wire logic o_pc_load,
    input wire logic [12:0] o_pc_value,
    input wire logic o_status_load,
    input wire logic [7:0] o_status_value,
    input wire logic o_irq_control_reg_load,
    input wire logic [7:0] o_irq_control_reg_value,
    input wire logic o_pc_high_clear
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    apb_ready_a: assert property (pready)
        else $error("pready low");
    por_hold_a: assert property (
        $rose(i_por_pulse) |-> ##[1:4] !o_core_reset_n)
        else $error("power-on pulse did not hold reset");
    wdt_run_a: assert property (
        o_core_reset_n && i_wdt_expire && !i_in_sleep && !i_por_pulse
        && !i_droop |=> !o_core_reset_n
        ##1 (o_status_load && o_status_value[4:3] == 2'b01))
        else $error("watchdog reset sequence wrong");
    reset_pc_a: assert property (
        o_pc_load && o_pc_high_clear |-> o_pc_value == 13'h0000)
        else $error("reset pc not zero");
    reset_ic_a: assert property (
        o_irq_control_reg_load && o_pc_high_clear |-> o_irq_control_reg_value[7:1] == 7'h00)
        else $error("reset irq_control_reg high bits not clear");
    reset_st_a: assert property (
        o_status_load && o_pc_high_clear |-> o_status_value[7:5] == 3'h0)
        else $error("reset status high bits not clear");
    wake_st_a: assert property (
        o_status_load && !o_pc_high_clear |-> !o_status_value[3])
        else $error("wake status sleep bit set");
    load_pair_a: assert property (
        o_pc_load |-> (o_status_load && o_irq_control_reg_load) ##1 !o_pc_load)
        else $error("load pulses not paired");
    cover property (o_pc_load && o_pc_high_clear);
    cover property (o_pc_load && !o_pc_high_clear);
    cover property ($rose(o_core_reset_n));
endmodule // rts_seq_props

bind rts_sequencer rts_seq_props rts_seq_props_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .pready(pready),
    .i_por_pulse(i_por_pulse), .i_droop(i_droop),
    .i_wdt_expire(i_wdt_expire), .i_in_sleep(i_in_sleep),
    .o_core_reset_n(o_core_reset_n), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_status_load(o_status_load),
    .o_status_value(o_status_value), .o_irq_control_reg_load(o_irq_control_reg_load),
    .o_irq_control_reg_value(o_irq_control_reg_value), .o_pc_high_clear(o_pc_high_clear)
);

// file: test/testbench.sv
// Self-checking bench of the reset and start-up sequencer.
`timescale 1ns/1ps
module testbench;
    import rts_pkg::*;
    localparam int FILT = 8;
    localparam int TICKS = 10;
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic i_por_pulse = 1'b0, i_droop = 1'b0, i_ext_reset_n = 1'b1;
    logic i_wdt_expire = 1'b0, i_irq_wake = 1'b0, i_in_sleep = 1'b0;
    logic i_osc_tick = 1'b1, i_intosc_tick = 1'b1;
    logic [12:0] i_pc = 13'h0123, o_pc_value;
    logic [7:0] i_status = 8'h07, i_irq_control_reg = 8'hff, i_wake_flags = 8'h02;
    logic [7:0] o_status_value, o_irq_control_reg_value;
    logic o_core_reset_n, o_pc_load, o_status_load, o_irq_control_reg_load;
    logic o_pc_high_clear;
    int failures = 0, num_checks = 0, cyc = 0, n;
    rts_sequencer #(.DROOP_FILTER_CYC(FILT), .POWERUP_TICKS(TICKS))
    rts_sequencer_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_por_pulse(i_por_pulse), .i_droop(i_droop),
        .i_ext_reset_n(i_ext_reset_n), .i_wdt_expire(i_wdt_expire),
        .i_irq_wake(i_irq_wake), .i_in_sleep(i_in_sleep),
        .i_osc_tick(i_osc_tick), .i_intosc_tick(i_intosc_tick),
        .i_pc(i_pc), .i_status(i_status), .i_irq_control_reg(i_irq_control_reg),
        .i_wake_flags(i_wake_flags), .o_core_reset_n(o_core_reset_n),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_status_load(o_status_load), .o_status_value(o_status_value),
        .o_irq_control_reg_load(o_irq_control_reg_load), .o_irq_control_reg_value(o_irq_control_reg_value),
        .o_pc_high_clear(o_pc_high_clear));
    initial
    begin
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input string w, input logic [31:0] s,
        input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge i_clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        do @(posedge i_clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic psr_chk(input logic [1:0] v);
        apb(1'b0, RTS_OFS_PSR, 32'h0);
        chk("psr", rd, {30'h0, v});
    endtask
    task automatic cause(input logic [2:0] c);
        apb(1'b0, RTS_OFS_STAT, 32'h0);
        chk("cause", {29'h0, rd[5:3]}, {29'h0, c});
    endtask
    task automatic wait_run(output int k);
        k = 0;
        while (o_core_reset_n !== 1'b1 && k < 3000)
        begin
            @(negedge i_clk_sys);
            k++;
        end
    endtask
    task automatic expect_load(input string w, input int lo, input int hi,
        input logic clr, input logic [12:0] pc, input logic [7:0] st,
        input logic [7:0] ic);
        int k;
        k = 0;
        while (o_pc_load !== 1'b1 && k < 3000)
        begin
            @(negedge i_clk_sys);
            k++;
        end
        chk({w, " time"}, {31'h0, k >= lo && k <= hi}, 32'h1);
        chk({w, " clr"}, {31'h0, o_pc_high_clear}, {31'h0, clr});
        chk({w, " pc"}, {19'h0, o_pc_value}, {19'h0, pc});
        chk({w, " st"}, {24'h0, o_status_value}, {24'h0, st});
        chk({w, " ic"}, {24'h0, o_irq_control_reg_value}, {24'h0, ic});
    endtask
    task automatic strobe(input int which);
        @(posedge i_clk_sys);
        if (which == 0)
            i_wdt_expire <= 1'b1;
        else
            i_irq_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_wdt_expire <= 1'b0;
        i_irq_wake <= 1'b0;
    endtask
    task automatic droop(input int len);
        @(posedge i_clk_sys);
        i_droop <= 1'b1;
        repeat (len) @(posedge i_clk_sys);
        i_droop <= 1'b0;
        repeat (4) @(negedge i_clk_sys);
    endtask
    task automatic pin(input logic sl, input logic [7:0] st);
        @(posedge i_clk_sys);
        i_in_sleep <= sl;
        i_ext_reset_n <= 1'b0;
        expect_load("pin", 0, 8, 1'b1, 13'h0, st, 8'h01);
        repeat (50) @(negedge i_clk_sys);
        chk("pin hold", {31'h0, o_core_reset_n}, 32'h0);
        @(posedge i_clk_sys);
        i_ext_reset_n <= 1'b1;
        i_in_sleep <= 1'b0;
        wait_run(n);
        chk("pin rise", {31'h0, n <= 4}, 32'h1);
    endtask
    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        apb(1'b0, RTS_OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        psr_chk(2'b00);
        @(posedge i_clk_sys);
        i_por_pulse <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_por_pulse <= 1'b0;
        expect_load("por", TICKS + RTS_SETTLE_CYCLES,
            TICKS + RTS_SETTLE_CYCLES + 10, 1'b1, 13'h0, 8'h1f, 8'h01);
        wait_run(n);
        psr_chk(2'b00);
        cause(3'd0);
        apb(1'b1, RTS_OFS_PSR, 32'h3);
        apb(1'b1, RTS_OFS_STAT, 32'h3f);
        chk("stat write", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        strobe(0);
        expect_load("wdt", 0, 4, 1'b1, 13'h0, 8'h0f, 8'h01);
        wait_run(n);
        psr_chk(2'b11);
        cause(3'd4);
        pin(1'b0, 8'h07);
        cause(3'd2);
        pin(1'b1, 8'h17);
        cause(3'd3);
        droop(20);
        chk("droop off", {31'h0, o_core_reset_n}, 32'h1);
        apb(1'b1, RTS_OFS_CTRL, 32'hf);
        apb(1'b0, RTS_OFS_CTRL, 32'h0);
        chk("ctrl rw", rd, 32'hf);
        droop(FILT - 3);
        chk("droop short", {31'h0, o_core_reset_n}, 32'h1);
        droop(30);
        chk("droop trip", {31'h0, o_core_reset_n}, 32'h0);
        droop(2);
        expect_load("droop", TICKS, TICKS + 6,
            1'b1, 13'h0, 8'h1f, 8'h01);
        wait_run(n);
        psr_chk(2'b10);
        cause(3'd1);
        apb(1'b1, RTS_OFS_CTRL, 32'hc);
        @(posedge i_clk_sys);
        i_in_sleep <= 1'b1;
        i_irq_control_reg <= 8'h80;
        strobe(1);
        expect_load("irq", 0, 4, 1'b0, 13'h4, 8'h17, 8'h82);
        @(posedge i_clk_sys);
        i_in_sleep <= 1'b0;
        wait_run(n);
        cause(3'd6);
        apb(1'b1, RTS_OFS_CTRL, 32'h4);
        @(posedge i_clk_sys);
        i_in_sleep <= 1'b1;
        i_status <= 8'hff;
        i_irq_control_reg <= 8'h00;
        strobe(0);
        expect_load("wake", RTS_SETTLE_CYCLES,
            RTS_SETTLE_CYCLES + 10, 1'b0, 13'h0124, 8'he7, 8'h02);
        @(posedge i_clk_sys);
        i_in_sleep <= 1'b0;
        wait_run(n);
        cause(3'd5);
        give_verdict();
    end
endmodule // testbench
